/* hdl/pmc_codec.sv */
// Purpose: encodes and decodes level-3 session and rate parameter octets
// Assumes: octet ports synchronous to i_clk; Avalon-MM slave with word addresses
// Notes:   octet bits 8 and 7 are carried for the framing logic only
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_codec
  import pmc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_tx_req,
  input  wire logic [1:0]  i_tx_group,
  input  wire logic [7:0]  i_tx_num,
  input  wire logic [1:0]  i_tx_frame_bits,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_octet,
  output logic             o_tx_unmapped,
  input  wire logic        i_rx_valid,
  input  wire logic [1:0]  i_rx_group,
  input  wire logic [7:0]  i_rx_num,
  input  wire logic [7:0]  i_rx_octet,
  output logic             o_rx_accept,
  output logic             o_rx_reserved,
  output logic      [31:0] o_rx_session
);

  logic [31:0] tx_sess_reg;
  logic [31:0] tx_sess_next;
  logic [31:0] rx_sess_reg;
  logic [31:0] rx_sess_next;
  logic [31:0] tx_rate_reg  [`PMC_RATE_ENTRIES];
  logic [31:0] tx_rate_next [`PMC_RATE_ENTRIES];
  logic [31:0] rx_rate_reg  [`PMC_RATE_ENTRIES];
  logic [31:0] rx_rate_next [`PMC_RATE_ENTRIES];
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        txv_reg;
  logic        txv_next;
  logic [7:0]  txo_reg;
  logic [7:0]  txo_next;
  logic        txu_reg;
  logic        txu_next;
  logic        rxa_reg;
  logic        rxa_next;
  logic        rxr_reg;
  logic        rxr_next;

  pmc_kind_t   tx_kind;
  logic [2:0]  tx_entry;
  pmc_kind_t   rx_kind;
  logic [2:0]  rx_entry;
  logic        rx_rsvd;
  logic [5:0]  rx_pay;
  logic [5:0]  tx_pay;
  logic [31:0] tx_rate_sel;
  logic        bus_take;
  logic        bus_wr;
  logic [3:0]  rate_idx;
  logic [3:0]  rx_idx;
  logic        in_tx_rate;
  logic        in_rx_rate;

  // bits 8 and 7 belong to framing, only the payload is decoded
  assign rx_pay = i_rx_octet[5:0];

  // payload tied off: the encode side only uses kind and entry
  pmc_octet_map u_tx_map (
    .i_group    (i_tx_group),
    .i_num      (i_tx_num),
    .i_payload  (`PMC_PAY_ZERO),
    .o_kind     (tx_kind),
    .o_entry    (tx_entry),
    .o_reserved ()
  );

  pmc_octet_map u_rx_map (
    .i_group    (i_rx_group),
    .i_num      (i_rx_num),
    .i_payload  (rx_pay),
    .o_kind     (rx_kind),
    .o_entry    (rx_entry),
    .o_reserved (rx_rsvd)
  );

  // one wait state per access; the access commits when waitrequest drops
  // read data is captured at the first edge so it stands at the completing one
  assign bus_take   = (i_avs_read || i_avs_write) && wait_reg;
  assign bus_wr     = i_avs_write && !wait_reg;
  assign rate_idx   = i_avs_address - `PMC_OFF_TX_RATE0;
  assign rx_idx     = i_avs_address - `PMC_OFF_RX_RATE0;
  assign in_tx_rate = i_avs_address >= `PMC_OFF_TX_RATE0 &&
                      i_avs_address < `PMC_OFF_TX_RATE0 + 4'(`PMC_RATE_ENTRIES);
  assign in_rx_rate = i_avs_address >= `PMC_OFF_RX_RATE0 &&
                      i_avs_address < `PMC_OFF_RX_RATE0 + 4'(`PMC_RATE_ENTRIES);

  always_comb begin
    wait_next  = !bus_take;
    rdata_next = rdata_reg;
    if (bus_take && i_avs_read) begin
      rdata_next = 32'h0000_0000;
      if (i_avs_address == `PMC_OFF_TX_SESS) begin
        rdata_next = tx_sess_reg;
      end else if (i_avs_address == `PMC_OFF_RX_SESS) begin
        rdata_next = rx_sess_reg;
      end else if (i_avs_address == `PMC_OFF_STATUS) begin
        rdata_next = {30'h0000_0000, status_reg};
      end else if (in_tx_rate) begin
        rdata_next = tx_rate_reg[rate_idx[2:0]];
      end else if (in_rx_rate) begin
        rdata_next = rx_rate_reg[rx_idx[2:0]];
      end
    end
  end

  // software side of the transmit fields
  always_comb begin
    tx_sess_next = tx_sess_reg;
    if (bus_wr && i_avs_address == `PMC_OFF_TX_SESS) begin
      tx_sess_next = i_avs_writedata & `PMC_SESS_MASK;
    end
  end

  // upstream entry has no step octet, so its low step bits stay idle
  genvar g;
  generate
    for (g = 0; g < `PMC_RATE_ENTRIES; g = g + 1) begin : g_rate
      always_comb begin
        tx_rate_next[g] = tx_rate_reg[g];
        if (bus_wr && i_avs_address == `PMC_OFF_TX_RATE0 + 4'(g)) begin
          tx_rate_next[g] = i_avs_writedata & `PMC_RATE_MASK;
        end
        rx_rate_next[g] = rx_rate_reg[g];
        if (i_rx_valid && !rx_rsvd && rx_entry == 3'(g)) begin
          case (rx_kind)
            PMC_K_MSB: begin
              rx_rate_next[g][`PMC_RATE_MIN_MSB]  = rx_pay[0];
              rx_rate_next[g][`PMC_RATE_MAX_MSB]  = rx_pay[1];
              rx_rate_next[g][`PMC_RATE_STEP_MSB] = rx_pay[2];
            end
            PMC_K_MIN:  rx_rate_next[g][`PMC_RATE_MIN_MSB-1:`PMC_RATE_MIN_LSB]   = rx_pay;
            PMC_K_MAX:  rx_rate_next[g][`PMC_RATE_MAX_MSB-1:`PMC_RATE_MAX_LSB]   = rx_pay;
            PMC_K_STEP: rx_rate_next[g][`PMC_RATE_STEP_MSB-1:`PMC_RATE_STEP_LSB] = rx_pay;
            default:    rx_rate_next[g] = rx_rate_reg[g];
          endcase
        end
      end
    end
  endgenerate

  // decoder: reserved octets leave stored fields untouched
  always_comb begin
    rx_sess_next = rx_sess_reg;
    rxa_next     = 1'b0;
    rxr_next     = 1'b0;
    if (i_rx_valid && rx_kind != PMC_K_NONE) begin
      rxr_next = rx_rsvd;
      rxa_next = !rx_rsvd;
      if (!rx_rsvd) begin
        case (rx_kind)
          PMC_K_BACKOFF: rx_sess_next[`PMC_SESS_BACKOFF_MSB:`PMC_SESS_BACKOFF_LSB] = rx_pay[4:0];
          PMC_K_DUR: rx_sess_next[`PMC_SESS_DUR_MSB:`PMC_SESS_DUR_LSB] = rx_pay;
          PMC_K_SCR: rx_sess_next[`PMC_SESS_SCR_MSB:`PMC_SESS_SCR_LSB] = rx_pay[2:0];
          PMC_K_WST: rx_sess_next[`PMC_SESS_WST_MSB:`PMC_SESS_WST_LSB] = rx_pay;
          PMC_K_CUR: rx_sess_next[`PMC_SESS_CUR_MSB:`PMC_SESS_CUR_LSB] = rx_pay;
          PMC_K_SIL: rx_sess_next[`PMC_SESS_SIL_BIT] = rx_pay[`PMC_PAY_SIL_BIT];
          default:   rx_sess_next = rx_sess_reg;
        endcase
      end
    end
  end

  // sticky status, set wins over a write-one clear
  always_comb begin
    status_next = status_reg;
    if (bus_wr && i_avs_address == `PMC_OFF_STATUS) begin
      status_next = status_reg & ~i_avs_writedata[1:0];
    end
    if (rxr_next) begin
      status_next[`PMC_STAT_RSVD_BIT] = 1'b1;
    end
    if (rxa_next) begin
      status_next[`PMC_STAT_SEEN_BIT] = 1'b1;
    end
  end

  // encoder
  // reserved codes never leave: they fall back to unspecified
  always_comb begin
    tx_rate_sel = tx_rate_reg[tx_entry];
    tx_pay      = `PMC_PAY_ZERO;
    case (tx_kind)
      PMC_K_BACKOFF: tx_pay = {1'b0, tx_sess_reg[`PMC_SESS_BACKOFF_MSB:`PMC_SESS_BACKOFF_LSB]};
      PMC_K_DUR: begin
        tx_pay = tx_sess_reg[`PMC_SESS_DUR_MSB:`PMC_SESS_DUR_LSB];
        if (tx_pay == `PMC_PAY_ONES) begin
          tx_pay = `PMC_PAY_ZERO;
        end
      end
      PMC_K_SCR: tx_pay = {3'h0, tx_sess_reg[`PMC_SESS_SCR_MSB:`PMC_SESS_SCR_LSB]};
      PMC_K_WST: begin
        tx_pay = tx_sess_reg[`PMC_SESS_WST_MSB:`PMC_SESS_WST_LSB];
        if (!tx_pay[`PMC_PAY_FLAG_BIT]) begin
          tx_pay = `PMC_PAY_ZERO;
        end
      end
      PMC_K_CUR: begin
        tx_pay = tx_sess_reg[`PMC_SESS_CUR_MSB:`PMC_SESS_CUR_LSB];
        if (!tx_pay[`PMC_PAY_FLAG_BIT]) begin
          tx_pay = `PMC_PAY_ZERO;
        end
      end
      PMC_K_SIL: tx_pay = {4'h0, tx_sess_reg[`PMC_SESS_SIL_BIT], 1'b0};
      PMC_K_MSB: tx_pay = {3'h0, tx_rate_sel[`PMC_RATE_STEP_MSB], tx_rate_sel[`PMC_RATE_MAX_MSB],
                           tx_rate_sel[`PMC_RATE_MIN_MSB]};
      PMC_K_MIN:  tx_pay = tx_rate_sel[`PMC_RATE_MIN_MSB-1:`PMC_RATE_MIN_LSB];
      PMC_K_MAX:  tx_pay = tx_rate_sel[`PMC_RATE_MAX_MSB-1:`PMC_RATE_MAX_LSB];
      PMC_K_STEP: tx_pay = tx_rate_sel[`PMC_RATE_STEP_MSB-1:`PMC_RATE_STEP_LSB];
      default:    tx_pay = `PMC_PAY_ZERO;
    endcase
    txv_next = i_tx_req && tx_kind != PMC_K_NONE;
    txu_next = i_tx_req && tx_kind == PMC_K_NONE;
    txo_next = txo_reg;
    if (txv_next) begin
      txo_next = {i_tx_frame_bits, tx_pay};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_sess_reg <= 32'h0000_0000;
      rx_sess_reg <= 32'h0000_0000;
      for (int i = 0; i < `PMC_RATE_ENTRIES; i++) begin
        tx_rate_reg[i] <= 32'h0000_0000;
        rx_rate_reg[i] <= 32'h0000_0000;
      end
      status_reg <= 2'h0;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h0000_0000;
      txv_reg    <= 1'b0;
      txo_reg    <= 8'h00;
      txu_reg    <= 1'b0;
      rxa_reg    <= 1'b0;
      rxr_reg    <= 1'b0;
    end else begin
      tx_sess_reg <= tx_sess_next;
      rx_sess_reg <= rx_sess_next;
      for (int i = 0; i < `PMC_RATE_ENTRIES; i++) begin
        tx_rate_reg[i] <= tx_rate_next[i];
        rx_rate_reg[i] <= rx_rate_next[i];
      end
      status_reg <= status_next;
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
      txv_reg    <= txv_next;
      txo_reg    <= txo_next;
      txu_reg    <= txu_next;
      rxa_reg    <= rxa_next;
      rxr_reg    <= rxr_next;
    end
  end

  // outputs are plain register copies, no decode after the flops
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_tx_valid        = txv_reg;
  assign o_tx_octet        = txo_reg;
  assign o_tx_unmapped     = txu_reg;
  assign o_rx_accept       = rxa_reg;
  assign o_rx_reserved     = rxr_reg;
  assign o_rx_session      = rx_sess_reg;

endmodule : pmc_codec
`default_nettype wire

/* hdl/pmc_consts.svh */
// Purpose: named constants of the parameter octet codec
// Assumes: included by bare name
// Notes:   word offsets on the register bus, field positions, codes
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// octet groups on the octet ports
`define PMC_GRP_US_SESS      2'h0
`define PMC_GRP_US_RATE      2'h1
`define PMC_GRP_DS_RATE      2'h2

// rate table: entry 0 upstream, entries 1..4 downstream
`define PMC_RATE_ENTRIES     5
`define PMC_DS_LAST_OCTET    8'h10
`define PMC_OCTET_ONE        8'h01
`define PMC_ENTRY_ONE        3'h1

// register word offsets
`define PMC_OFF_TX_SESS      4'h0
`define PMC_OFF_TX_RATE0     4'h1
`define PMC_OFF_RX_SESS      4'h8
`define PMC_OFF_RX_RATE0     4'h9
`define PMC_OFF_STATUS       4'hF

// session word layout
`define PMC_SESS_BACKOFF_LSB 0
`define PMC_SESS_BACKOFF_MSB 4
`define PMC_SESS_DUR_LSB     5
`define PMC_SESS_DUR_MSB     10
`define PMC_SESS_SCR_LSB     11
`define PMC_SESS_SCR_MSB     13
`define PMC_SESS_SIL_BIT     14
`define PMC_SESS_WST_LSB     15
`define PMC_SESS_WST_MSB     20
`define PMC_SESS_CUR_LSB     21
`define PMC_SESS_CUR_MSB     26
`define PMC_SESS_MASK        32'h07FF_FFFF

// rate word layout
`define PMC_RATE_MIN_LSB     0
`define PMC_RATE_MIN_MSB     6
`define PMC_RATE_MAX_LSB     8
`define PMC_RATE_MAX_MSB     14
`define PMC_RATE_STEP_LSB    16
`define PMC_RATE_STEP_MSB    22
`define PMC_RATE_MASK        32'h007F_7F7F
`define PMC_RATE_HI          6

// status bits
`define PMC_STAT_RSVD_BIT    0
`define PMC_STAT_SEEN_BIT    1

// payload codes (bits 6..1 of an octet)
`define PMC_PAY_ZERO         6'h00
`define PMC_PAY_ONES         6'h3F
`define PMC_PAY_FLAG_BIT     5
`define PMC_PAY_SIL_BIT      1
`define PMC_SIL_RSVD_MASK    6'h3D
`define PMC_HI3_MASK         6'h38

// units of the coded values
`define PMC_BACKOFF_STEP_DB  1
`define PMC_DUR_UNIT_MS      50
`define PMC_MARGIN_OFS_DB    10

`endif

/* hdl/pmc_octet_map.sv */
// Purpose: maps group and octet number to a kind and rate entry, flags reserved payloads
// Assumes: payload is bits 6..1 of the octet
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_octet_map
  import pmc_pkg::*;
(
  input  wire logic [1:0] i_group,
  input  wire logic [7:0] i_num,
  input  wire logic [5:0] i_payload,
  output var  pmc_kind_t  o_kind,
  output logic      [2:0] o_entry,
  output logic            o_reserved
);

  logic [7:0] dn_off;

  always_comb begin
    o_kind  = PMC_K_NONE;
    o_entry = 3'h0;
    dn_off  = i_num - `PMC_OCTET_ONE;
    case (i_group)
      `PMC_GRP_US_SESS: begin
        case (i_num)
          8'h01: o_kind = PMC_K_BACKOFF;
          8'h02: o_kind = PMC_K_DUR;
          8'h03: o_kind = PMC_K_SCR;
          8'h04: o_kind = PMC_K_WST;
          8'h05: o_kind = PMC_K_CUR;
          8'h06: o_kind = PMC_K_SIL;
          default: o_kind = PMC_K_NONE;
        endcase
      end
      `PMC_GRP_US_RATE: begin
        case (i_num)
          8'h01: o_kind = PMC_K_MSB;
          8'h02: o_kind = PMC_K_MIN;
          8'h03: o_kind = PMC_K_MAX;
          default: o_kind = PMC_K_NONE;
        endcase
      end
      `PMC_GRP_DS_RATE: begin
        if (i_num >= `PMC_OCTET_ONE && i_num <= `PMC_DS_LAST_OCTET) begin
          o_entry = dn_off[4:2] + `PMC_ENTRY_ONE;
          case (dn_off[1:0])
            2'h0: o_kind = PMC_K_MSB;
            2'h1: o_kind = PMC_K_MIN;
            2'h2: o_kind = PMC_K_MAX;
            default: o_kind = PMC_K_STEP;
          endcase
        end
      end
      default: o_kind = PMC_K_NONE;
    endcase
  end

  always_comb begin
    case (o_kind)
      PMC_K_BACKOFF: o_reserved = i_payload[`PMC_PAY_FLAG_BIT];
      PMC_K_DUR: o_reserved = (i_payload == `PMC_PAY_ONES);
      PMC_K_SCR: o_reserved = |(i_payload & `PMC_HI3_MASK);
      PMC_K_WST,
      PMC_K_CUR: o_reserved = !i_payload[`PMC_PAY_FLAG_BIT] && (i_payload != `PMC_PAY_ZERO);
      PMC_K_SIL: o_reserved = |(i_payload & `PMC_SIL_RSVD_MASK);
      PMC_K_MSB: o_reserved = |(i_payload & `PMC_HI3_MASK);
      default:   o_reserved = 1'b0;
    endcase
  end

endmodule : pmc_octet_map
`default_nettype wire

/* hdl/pmc_pkg.sv */
// Purpose: types shared by the parameter octet codec
// Assumes: nothing
// Notes:   octet kinds after mapping group and octet number
package pmc_pkg;

  typedef enum logic [3:0] {
    PMC_K_NONE,
    PMC_K_BACKOFF,
    PMC_K_DUR,
    PMC_K_SCR,
    PMC_K_WST,
    PMC_K_CUR,
    PMC_K_SIL,
    PMC_K_MSB,
    PMC_K_MIN,
    PMC_K_MAX,
    PMC_K_STEP
  } pmc_kind_t;

endpackage : pmc_pkg

/* verification/pmc_codec_asserts.sv */
// Purpose: port checker of the parameter octet codec
// Assumes: one clock, async active-high reset
// Notes:   bound to pmc_codec below
`timescale 1ns/100ps
`default_nettype none
module pmc_codec_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_tx_req,
  input wire logic [1:0]  i_tx_group,
  input wire logic [7:0]  i_tx_num,
  input wire logic [1:0]  i_tx_frame_bits,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_octet,
  input wire logic        o_tx_unmapped,
  input wire logic        i_rx_valid,
  input wire logic [1:0]  i_rx_group,
  input wire logic [7:0]  i_rx_num,
  input wire logic [7:0]  i_rx_octet,
  input wire logic        o_rx_accept,
  input wire logic        o_rx_reserved,
  input wire logic [31:0] o_rx_session
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic  s_req = i_tx_req && i_tx_group == 2'h0;
  wire logic  hi_req = i_tx_req && ((i_tx_group == 2'h1 && i_tx_num == 8'h01) ||
                       (i_tx_group == 2'h2 && i_tx_num[1:0] == 2'h1 && i_tx_num <= 8'h10));
  logic [7:0] rx_oct_q;
  // octet of the previous cycle, $past cannot be sliced
  always_ff @(posedge i_clk) rx_oct_q <= i_rx_octet;
  a_backoff_bit6: assert property (s_req && i_tx_num == 8'h01 |=> o_tx_valid && !o_tx_octet[5])
    else $error("backoff octet bit 6 set");
  a_dur_ones: assert property (s_req && i_tx_num == 8'h02 |=> o_tx_valid && o_tx_octet[5:0] != 6'h3F)
    else $error("all-ones duration sent");
  a_scr_zero: assert property (s_req && i_tx_num == 8'h03 |=> o_tx_valid && o_tx_octet[5:3] == 3'h0)
    else $error("scrambler octet high bits set");
  a_margin_code: assert property (s_req && (i_tx_num == 8'h04 || i_tx_num == 8'h05) |=>
    o_tx_valid && (o_tx_octet[5] || o_tx_octet[5:0] == 6'h00))
    else $error("reserved margin code sent");
  a_sil_only: assert property (s_req && i_tx_num == 8'h06 |=> (o_tx_octet[5:0] & 6'h3D) == 6'h00)
    else $error("reserved silence bit sent");
  a_msb_high: assert property (hi_req |=> o_tx_valid && o_tx_octet[5:3] == 3'h0)
    else $error("rate high-bit octet reserved bits set");
  a_frame_pass: assert property (o_tx_valid |-> o_tx_octet[7:6] == $past(i_tx_frame_bits))
    else $error("framing bits altered");
  a_tx_unmap: assert property (i_tx_req && (i_tx_group == 2'h3 || (i_tx_group == 2'h2 && i_tx_num > 8'h10))
    |=> o_tx_unmapped && !o_tx_valid)
    else $error("unknown octet encoded");
  a_rx_rsvd: assert property (i_rx_valid && i_rx_group == 2'h0 && i_rx_num == 8'h01 && i_rx_octet[5]
    |=> o_rx_reserved && !o_rx_accept)
    else $error("reserved backoff not flagged");
  a_rsv_hold: assert property (o_rx_reserved |-> $stable(o_rx_session))
    else $error("reserved octet stored");
  a_rx_dur: assert property (i_rx_valid && i_rx_group == 2'h0 && i_rx_num == 8'h02 && i_rx_octet[5:0] != 6'h3F
    |=> o_rx_accept && o_rx_session[10:5] == rx_oct_q[5:0])
    else $error("duration not decoded");
  c_rsv: cover property (o_rx_reserved);
  c_unmap: cover property (o_tx_unmapped);
  c_acc: cover property (o_rx_accept ##2 o_rx_accept);
endmodule : pmc_codec_asserts
bind pmc_codec pmc_codec_asserts i_chk (.i_clk, .i_rst, .i_tx_req, .i_tx_group, .i_tx_num, .i_tx_frame_bits,
  .o_tx_valid, .o_tx_octet, .o_tx_unmapped, .i_rx_valid, .i_rx_group, .i_rx_num, .i_rx_octet, .o_rx_accept,
  .o_rx_reserved, .o_rx_session);
`default_nettype wire

/* verification/pmc_far_model.sv */
// Purpose: remote transceiver end sending received octets
// Assumes: send is called by the bench
// Notes:   idle num and octet lines show the inverse of the last value, group holds
`timescale 1ns/100ps
`default_nettype none
module pmc_far_model (
  input  wire logic       i_clk,
  output logic            o_valid,
  output logic      [1:0] o_group,
  output logic      [7:0] o_num,
  output logic      [7:0] o_octet
);
  initial begin
    o_valid = 1'b0;
    o_group = 2'h0;
    o_num   = 8'h00;
    o_octet = 8'h00;
  end
  task automatic send(input logic [1:0] g, input logic [7:0] n, input logic [7:0] o);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_group <= g;
    o_num   <= n;
    o_octet <= o;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_num   <= ~n;
    o_octet <= ~o;
  endtask : send
endmodule : pmc_far_model
`default_nettype wire

/* verification/tb_pmc_codec.sv */
// Purpose: self-checking bench of the parameter octet codec
// Assumes: far end fed through pmc_far_model
// Notes:   expected octets built from the field layout
`timescale 1ns/100ps
`default_nettype none
module tb_pmc_codec;
  logic        i_clk, i_rst, i_avs_read, i_avs_write, i_tx_req, o_avs_waitrequest;
  logic        o_tx_valid, o_tx_unmapped, i_rx_valid, o_rx_accept, o_rx_reserved;
  logic [3:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_rx_session, q, w;
  logic [1:0]  i_tx_group, i_tx_frame_bits, i_rx_group;
  logic [7:0]  i_tx_num, i_rx_num, i_rx_octet, o_tx_octet;
  logic [6:0]  mn [5], mx [5], st [5];
  logic [17:0] rsv [9];
  int          bad_count, checks_done, n, e;
  pmc_codec i_dut (.i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .i_tx_req, .i_tx_group, .i_tx_num, .i_tx_frame_bits, .o_tx_valid, .o_tx_octet,
    .o_tx_unmapped, .i_rx_valid, .i_rx_group, .i_rx_num, .i_rx_octet, .o_rx_accept, .o_rx_reserved, .o_rx_session);
  pmc_far_model i_far (.i_clk, .o_valid(i_rx_valid), .o_group(i_rx_group), .o_num(i_rx_num), .o_octet(i_rx_octet));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge i_clk);
    i_avs_read      <= !wr;
    i_avs_write     <= wr;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (i == 20) begin
      bad_count++;
      conclude();
    end
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd_chk
  // exp holds {unmapped, octet}; its bits 7..6 are the framing bits sent
  task automatic tx(input logic [1:0] g, input logic [7:0] nm, input logic [8:0] exp);
    @(posedge i_clk);
    i_tx_req        <= 1'b1;
    i_tx_group      <= g;
    i_tx_num        <= nm;
    i_tx_frame_bits <= exp[7:6];
    @(posedge i_clk);
    i_tx_req <= 1'b0;
    #1;
    check(32'({o_tx_unmapped, o_tx_valid, o_tx_octet}), 32'({exp[8], !exp[8], exp[7:0]}));
  endtask : tx
  task automatic rx(input logic [1:0] g, input logic [7:0] nm, input logic [7:0] o, input logic [1:0] exp);
    i_far.send(g, nm, o);
    #1;
    check(32'({o_rx_accept, o_rx_reserved}), 32'(exp));
  endtask : rx
  task automatic sess(input logic [31:0] v, input logic [5:0] ed, input logic [5:0] ew, input logic [5:0] ec);
    bus(1'b1, 4'h0, v);
    tx(2'h0, 8'h01, {3'b010, 1'b0, v[4:0]});
    tx(2'h0, 8'h02, {3'b010, ed});
    tx(2'h0, 8'h03, {3'b010, 3'h0, v[13:11]});
    tx(2'h0, 8'h04, {3'b010, ew});
    tx(2'h0, 8'h05, {3'b010, ec});
    tx(2'h0, 8'h06, {3'b010, 4'h0, v[14], 1'b0});
  endtask : sess
  // index i: entry i/4, position i%4 (high bits, min, max, step)
  function automatic logic [5:0] roct(input int i);
    int k;
    k = i / 4;
    case (i % 4)
      0: return {3'h0, st[k][6], mx[k][6], mn[k][6]};
      1: return mn[k][5:0];
      2: return mx[k][5:0];
      default: return st[k][5:0];
    endcase
  endfunction : roct
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    {i_rst, i_avs_read, i_avs_write, i_tx_req, i_avs_address, i_avs_writedata} = {4'h8, 36'h0};
    {i_tx_group, i_tx_num, i_tx_frame_bits, bad_count, checks_done} = '0;
    rsv = '{18'h0_01E0, 18'h0_023F, 18'h0_0308, 18'h0_0401, 18'h0_051F, 18'h0_0601, 18'h0_0620,
            18'h1_0108, 18'h2_0910};
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(4'hF, 32'h0000_0000);
    sess({5'h00, 6'h20, 6'h25, 1'b1, 3'h5, 6'h2A, 5'h13}, 6'h2A, 6'h25, 6'h20);
    sess({5'h00, 6'h1F, 6'h05, 1'b0, 3'h0, 6'h3F, 5'h00}, 6'h00, 6'h00, 6'h00);
    for (e = 0; e < 5; e++) begin
      mn[e] = {e[0], 6'(e + 8)};
      mx[e] = {!e[0], 6'(e + 48)};
      st[e] = {e[1], 6'(e + 32)};
      bus(1'b1, 4'(e + 1), {9'h000, st[e], 1'b0, mx[e], 1'b0, mn[e]});
    end
    for (n = 1; n < 20; n++) tx(n < 4 ? 2'h1 : 2'h2, 8'(n < 4 ? n : n - 3), {3'b001, roct(n < 4 ? n - 1 : n)});
    tx(2'h3, 8'h01, {3'b101, roct(19)});
    tx(2'h2, 8'h11, {3'b101, roct(19)});
    w = {5'h00, 6'h20, 6'h3F, 1'b1, 3'h7, 6'h3E, 5'h1F};
    rx(2'h0, 8'h01, {3'b110, w[4:0]}, 2'b10);
    rx(2'h0, 8'h02, {2'b11, w[10:5]}, 2'b10);
    rx(2'h0, 8'h03, {5'h08, w[13:11]}, 2'b10);
    rx(2'h0, 8'h04, {2'b10, w[20:15]}, 2'b10);
    rx(2'h0, 8'h05, {2'b00, w[26:21]}, 2'b10);
    rx(2'h0, 8'h06, {6'h30, w[14], 1'b0}, 2'b10);
    for (n = 0; n < 9; n++) rx(rsv[n][17:16], rsv[n][15:8], rsv[n][7:0], 2'b01);
    rx(2'h3, 8'h01, 8'h00, 2'b00);
    rx(2'h0, 8'h07, 8'h00, 2'b00);
    check(o_rx_session, w);
    rx(2'h0, 8'h04, 8'hC0, 2'b10);
    check(o_rx_session, {w[31:21], 6'h00, w[14:0]});
    for (e = 0; e < 5; e++) {mn[e], mx[e], st[e]} = ~{mn[e], mx[e], st[e]};
    for (n = 1; n < 20; n++)
      rx(n < 4 ? 2'h1 : 2'h2, 8'(n < 4 ? n : n - 3), {2'b10, roct(n < 4 ? n - 1 : n)}, 2'b10);
    // upstream entry has no step low-bit octet, so those stay at reset
    for (e = 0; e < 5; e++)
      rd_chk(4'(e + 9), {9'h0, st[e][6], e == 0 ? 6'h00 : st[e][5:0], 1'b0, mx[e], 1'b0, mn[e]});
    rd_chk(4'hF, 32'h0000_0003);
    bus(1'b1, 4'hF, 32'h0000_0001);
    rd_chk(4'hF, 32'h0000_0002);
    bus(1'b1, 4'h6, 32'hFFFF_FFFF);
    rd_chk(4'h6, 32'h0000_0000);
    conclude();
  end
endmodule : tb_pmc_codec
`default_nettype wire
